// ==== agu_consts.svh ====
`ifndef AGU_CONSTS_SVH
`define AGU_CONSTS_SVH

// ==========================================
// Register indexes (byte address = index * 4)
`define AGU_IDX_MODE_CTRL   8'h46
`define AGU_IDX_X_START     8'h48
`define AGU_IDX_X_END       8'h4a
`define AGU_IDX_Y_START     8'h4c
`define AGU_IDX_Y_END       8'h4e
`define AGU_IDX_REV_CTRL    8'h50
`define AGU_IDX_STATUS      8'h60

// ==========================================
// Mode control, reverse control and status field positions
`define AGU_MC_X_EN_BIT     15
`define AGU_MC_Y_EN_BIT     14
`define AGU_MC_REV_SEL_LSB  8
`define AGU_MC_Y_SEL_LSB    4
`define AGU_MC_X_SEL_LSB    0
`define AGU_REV_EN_BIT      15
`define AGU_STAT_FAULT_BIT  16

// ==========================================
// Reset values and constants
`define AGU_MODE_CTRL_RST   16'h0000
`define AGU_REV_CTRL_RST    16'h0000
`define AGU_SEL_NONE        4'hf
`define AGU_NEAR_BITS       13
`define AGU_LATENCY         1
`define AGU_RESP_OKAY       2'h0
`define AGU_RESP_SLVERR     2'h2

`endif

// ==== agu_pkg.sv ====
package agu_pkg;

  // ==========================================
  // Addressing modes from the decoder
  typedef enum logic [2:0] {
    MODE_FILE_DIRECT,
    MODE_REG_DIRECT,
    MODE_INDIRECT,
    MODE_POST_MOD,
    MODE_PRE_MOD,
    MODE_REG_OFFSET,
    MODE_LIT_OFFSET
  } agu_mode_t;

  // ==========================================
  // Request from decoder and register file
  typedef struct packed {
    logic        valid;
    logic        y_space;
    logic        prog_space;
    logic        mac_class;
    logic        byte_op;
    logic        move_full;
    agu_mode_t   mode;
    logic [3:0]  ptr_sel;
    logic [15:0] ptr_val;
    logic [3:0]  base_sel;
    logic [15:0] base_val;
    logic [15:0] literal;
    logic [12:0] file_addr;
    logic [15:0] move_addr;
  } agu_req_t;

  // ==========================================
  // Answer to the core
  typedef struct packed {
    logic        valid;
    logic        fault;
    logic [15:0] ea;
    logic        ea_used;
    logic [15:0] operand1;
    logic        operand_is_reg;
    logic [15:0] operand2;
    logic [3:0]  dest_sel;
    logic        wb_en;
    logic [3:0]  wb_sel;
    logic [15:0] wb_val;
    logic        circ_applied;
    logic        rev_applied;
  } agu_resp_t;

endpackage

// ==== address_generator_units.sv ====
`timescale 1ns/1ps
`include "agu_consts.svh"

// Notes on behaviour
// [R1] Separate X and Y generators, independent
// [R2] Y generator: word reads, MAC only
// [R3] Linear and circular for data and program
// [R4] Bit-reversed never on program space
// [R5] File direct uses 13-bit near field
// [R6] File ops default to working register zero
// [R7] Move may address whole data space
// [R8] Operand one is base register direct
// [R9] Direct, indirect, pre, post, literal modes
// [R10] File direct explicit; register direct is operand
// [R11] Indirect: address is pointer, unmodified
// [R12] Post-modify: issue pointer, then adjust
// [R13] Pre-modify: adjust pointer, then issue
// [R14] Register offset: pointer plus base
// [R15] Literal offset: pointer plus literal
// [R16] X circular needs enable, select not 15
// [R17] Y circular needs enable, select not 15
// [R18] Reversed needs select, enable, increment mode
// [R19] Circular write-back only on pre/post modify
// [R20] Addresses 16-bit, arithmetic wraps
module address_generator_units #(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // Decoder request and answer
  input  wire agu_pkg::agu_req_t req,
  output agu_pkg::agu_resp_t     resp,
  // AXI4-Lite write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);
  import agu_pkg::*;

  // ==========================================
  // Elaboration check
  if (ADDR_W < 9 || ADDR_W > 32) begin : g_bad_width
    $error("ADDR_W must be between 9 and 32");
  end

  // ==========================================
  // State
  typedef struct packed {
    logic              x_en;
    logic              y_en;
    logic [3:0]        rev_sel;
    logic [3:0]        y_sel;
    logic [3:0]        x_sel;
    logic [14:0]       x_start;
    logic [14:0]       x_end;
    logic [14:0]       y_start;
    logic [14:0]       y_end;
    logic              rev_en;
    logic [14:0]       rev_mod;
    logic              aw_v;
    logic [ADDR_W-1:0] aw_a;
    logic              w_v;
    logic [31:0]       w_d;
    logic [3:0]        w_s;
    logic              b_v;
    logic [1:0]        b_r;
    logic              r_v;
    logic [31:0]       r_d;
    logic [1:0]        r_r;
    agu_resp_t         out;
    logic [15:0]       last_ea;
    logic              last_fault;
  } state_t;

  state_t s_q;
  state_t s_d;

  // ==========================================
  // Helpers
  function automatic logic [15:0] rev16(input logic [15:0] v);
    logic [15:0] r;
    r = '0;
    for (int i = 0; i < 16; i++) begin
      r[i] = v[15-i];
    end
    return r;
  endfunction

  function automatic logic [15:0] circ_fix(input logic [15:0] a,
                                           input logic [15:0] lo,
                                           input logic [15:0] hi);
    logic [15:0] len;
    len = 16'(hi - lo + 16'h0001);
    if (a > hi) begin
      return 16'(a - len);
    end else if (a < lo) begin
      return 16'(a + len);
    end
    return a;
  endfunction

  function automatic logic [ADDR_W-1:0] reg_addr(input logic [7:0] idx);
    return ADDR_W'({idx, 2'b00});
  endfunction

  // ==========================================
  // Address datapath
  logic [15:0] x_lo;
  logic [15:0] x_hi;
  logic [15:0] y_lo;
  logic [15:0] y_hi;
  logic        x_circ_on;
  logic        y_circ_on;
  logic        rev_on;
  logic        circ_hit;
  logic        y_refuse;
  logic        is_inc;
  logic [15:0] delta;
  logic [15:0] stepped;
  logic [15:0] rev_step;
  logic [15:0] lo_b;
  logic [15:0] hi_b;
  agu_resp_t   r;

  assign x_lo = {s_q.x_start, 1'b0};
  assign x_hi = {s_q.x_end, 1'b1};
  assign y_lo = {s_q.y_start, 1'b0};
  assign y_hi = {s_q.y_end, 1'b1};
  assign x_circ_on = s_q.x_en && s_q.x_sel != `AGU_SEL_NONE; // [R16]
  assign y_circ_on = s_q.y_en && s_q.y_sel != `AGU_SEL_NONE; // [R17]
  assign delta = req.literal;
  assign is_inc = !delta[15] && delta != 16'h0000;
  assign stepped = 16'(req.ptr_val + delta); // [R20]
  assign rev_step = rev16(16'(rev16(req.ptr_val) + rev16({s_q.rev_mod, 1'b0})));
  // Reversed carry only for X data, increment pre/post modes
  assign rev_on = s_q.rev_en && s_q.rev_sel != `AGU_SEL_NONE // [R18]
               && s_q.rev_sel == req.ptr_sel && is_inc && !req.y_space
               && !req.prog_space // [R4]
               && (req.mode == MODE_PRE_MOD || req.mode == MODE_POST_MOD);
  // Each space checks only its own window
  assign circ_hit = req.y_space ? (y_circ_on && req.ptr_sel == s_q.y_sel) // [R1]
                                : (x_circ_on && req.ptr_sel == s_q.x_sel); // [R3]
  assign lo_b = req.y_space ? y_lo : x_lo;
  assign hi_b = req.y_space ? y_hi : x_hi;
  assign y_refuse = req.y_space && (req.byte_op || !req.mac_class); // [R2]

  always_comb begin
    r = '0;
    r.valid = req.valid;
    r.operand1 = req.base_val; // [R8]
    r.dest_sel = req.base_sel;
    r.operand2 = req.literal;
    if (y_refuse) begin
      r.fault = 1'b1;
    end else begin
      case (req.mode) // [R9]
        MODE_FILE_DIRECT: begin
          r.ea_used = 1'b1;
          r.dest_sel = 4'h0; // [R6]
          if (req.move_full) begin
            r.ea = req.move_addr; // [R7]
          end else begin
            r.ea = {3'b000, req.file_addr}; // [R5] [R10]
          end
        end
        MODE_REG_DIRECT: begin
          r.operand_is_reg = 1'b1;
          r.operand2 = req.ptr_val; // [R10]
        end
        MODE_INDIRECT: begin
          r.ea_used = 1'b1;
          r.ea = req.ptr_val; // [R11]
        end
        MODE_POST_MOD: begin
          r.ea_used = 1'b1;
          r.ea = req.ptr_val; // [R12]
          r.wb_en = 1'b1;
          r.wb_val = stepped;
          if (rev_on) begin
            r.wb_val = rev_step;
            r.rev_applied = 1'b1;
          end else if (circ_hit) begin
            r.wb_val = circ_fix(stepped, lo_b, hi_b); // [R19]
            r.circ_applied = 1'b1;
          end
        end
        MODE_PRE_MOD: begin
          r.ea_used = 1'b1;
          r.wb_en = 1'b1;
          r.ea = stepped; // [R13]
          if (rev_on) begin
            r.ea = rev_step;
            r.rev_applied = 1'b1;
          end else if (circ_hit) begin
            r.ea = circ_fix(stepped, lo_b, hi_b); // [R19]
            r.circ_applied = 1'b1;
          end
          r.wb_val = r.ea;
        end
        MODE_REG_OFFSET: begin
          r.ea_used = 1'b1;
          r.ea = 16'(req.ptr_val + req.base_val); // [R14]
          if (circ_hit) begin
            r.ea = circ_fix(r.ea, lo_b, hi_b); // [R19]
            r.circ_applied = 1'b1;
          end
        end
        MODE_LIT_OFFSET: begin
          r.ea_used = 1'b1;
          r.ea = 16'(req.ptr_val + req.literal); // [R15]
          if (circ_hit) begin
            r.ea = circ_fix(r.ea, lo_b, hi_b);
            r.circ_applied = 1'b1;
          end
        end
        default: begin
          r.fault = 1'b1;
        end
      endcase
      if (req.y_space) begin
        r.ea[0] = 1'b0;
        r.wb_val[0] = 1'b0;
      end
    end
    r.wb_sel = req.ptr_sel;
    if (!req.valid) begin
      r = '0;
    end
  end

  // ==========================================
  // Next state and register bus
  logic        wr_fire;
  logic [15:0] wd;
  logic        hit_w;
  logic        hit_r;
  logic [31:0] rd;

  assign s_axi_awready = !s_q.aw_v && !s_q.b_v;
  assign s_axi_wready  = !s_q.w_v && !s_q.b_v;
  assign s_axi_arready = !s_q.r_v;
  assign s_axi_bvalid  = s_q.b_v;
  assign s_axi_bresp   = s_q.b_r;
  assign s_axi_rvalid  = s_q.r_v;
  assign s_axi_rdata   = s_q.r_d;
  assign s_axi_rresp   = s_q.r_r;
  assign resp          = s_q.out;

  always_comb begin
    s_d = s_q;
    wr_fire = 1'b0;
    hit_w = 1'b0;
    hit_r = 1'b1;
    rd = 32'h0000_0000;
    wd = 16'h0000;
    s_d.out = r;
    if (r.valid) begin
      s_d.last_ea = r.ea;
      s_d.last_fault = r.fault;
    end
    if (s_axi_awvalid && s_axi_awready) begin
      s_d.aw_v = 1'b1;
      s_d.aw_a = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_d.w_v = 1'b1;
      s_d.w_d = s_axi_wdata;
      s_d.w_s = s_axi_wstrb;
    end
    if (s_q.aw_v && s_q.w_v) begin
      wr_fire = 1'b1;
      s_d.aw_v = 1'b0;
      s_d.w_v = 1'b0;
      s_d.b_v = 1'b1;
    end
    if (s_q.b_v && s_axi_bready) begin
      s_d.b_v = 1'b0;
    end
    if (wr_fire) begin
      if (s_q.aw_a == reg_addr(`AGU_IDX_MODE_CTRL)) begin
        wd = {s_q.x_en, s_q.y_en, 2'b00, s_q.rev_sel, s_q.y_sel, s_q.x_sel};
        hit_w = 1'b1;
      end else if (s_q.aw_a == reg_addr(`AGU_IDX_X_START)) begin
        wd = x_lo;
        hit_w = 1'b1;
      end else if (s_q.aw_a == reg_addr(`AGU_IDX_X_END)) begin
        wd = x_hi;
        hit_w = 1'b1;
      end else if (s_q.aw_a == reg_addr(`AGU_IDX_Y_START)) begin
        wd = y_lo;
        hit_w = 1'b1;
      end else if (s_q.aw_a == reg_addr(`AGU_IDX_Y_END)) begin
        wd = y_hi;
        hit_w = 1'b1;
      end else if (s_q.aw_a == reg_addr(`AGU_IDX_REV_CTRL)) begin
        wd = {s_q.rev_en, s_q.rev_mod};
        hit_w = 1'b1;
      end
      if (s_q.w_s[0]) begin
        wd[7:0] = s_q.w_d[7:0];
      end
      if (s_q.w_s[1]) begin
        wd[15:8] = s_q.w_d[15:8];
      end
      s_d.b_r = hit_w ? `AGU_RESP_OKAY : `AGU_RESP_SLVERR;
      if (s_q.aw_a == reg_addr(`AGU_IDX_MODE_CTRL)) begin
        s_d.x_en = wd[`AGU_MC_X_EN_BIT];
        s_d.y_en = wd[`AGU_MC_Y_EN_BIT];
        s_d.rev_sel = wd[`AGU_MC_REV_SEL_LSB +: 4];
        s_d.y_sel = wd[`AGU_MC_Y_SEL_LSB +: 4];
        s_d.x_sel = wd[`AGU_MC_X_SEL_LSB +: 4];
      end else if (s_q.aw_a == reg_addr(`AGU_IDX_X_START)) begin
        s_d.x_start = wd[15:1];
      end else if (s_q.aw_a == reg_addr(`AGU_IDX_X_END)) begin
        s_d.x_end = wd[15:1];
      end else if (s_q.aw_a == reg_addr(`AGU_IDX_Y_START)) begin
        s_d.y_start = wd[15:1];
      end else if (s_q.aw_a == reg_addr(`AGU_IDX_Y_END)) begin
        s_d.y_end = wd[15:1];
      end else if (s_q.aw_a == reg_addr(`AGU_IDX_REV_CTRL)) begin
        s_d.rev_en = wd[`AGU_REV_EN_BIT];
        s_d.rev_mod = wd[14:0];
      end
    end
    if (s_axi_araddr == reg_addr(`AGU_IDX_MODE_CTRL)) begin
      rd = {16'h0000, s_q.x_en, s_q.y_en, 2'b00, s_q.rev_sel, s_q.y_sel, s_q.x_sel};
    end else if (s_axi_araddr == reg_addr(`AGU_IDX_X_START)) begin
      rd = {16'h0000, x_lo};
    end else if (s_axi_araddr == reg_addr(`AGU_IDX_X_END)) begin
      rd = {16'h0000, x_hi};
    end else if (s_axi_araddr == reg_addr(`AGU_IDX_Y_START)) begin
      rd = {16'h0000, y_lo};
    end else if (s_axi_araddr == reg_addr(`AGU_IDX_Y_END)) begin
      rd = {16'h0000, y_hi};
    end else if (s_axi_araddr == reg_addr(`AGU_IDX_REV_CTRL)) begin
      rd = {16'h0000, s_q.rev_en, s_q.rev_mod};
    end else if (s_axi_araddr == reg_addr(`AGU_IDX_STATUS)) begin
      rd = {15'h0000, s_q.last_fault, s_q.last_ea};
    end else begin
      hit_r = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      s_d.r_v = 1'b1;
      s_d.r_d = rd;
      s_d.r_r = hit_r ? `AGU_RESP_OKAY : `AGU_RESP_SLVERR;
    end else if (s_q.r_v && s_axi_rready) begin
      s_d.r_v = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================
  // Assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic plain_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      plain_q <= 1'b0;
    end else begin
      plain_q <= !circ_hit && !rev_on && !y_refuse && !req.y_space;
    end
  end

  sequence s_req(agu_mode_t m);
    req.valid && req.mode == m;
  endsequence

  file_direct_a: assert property (s_req(MODE_FILE_DIRECT) ##0 (!req.move_full && !y_refuse) // [R5]
    |=> resp.ea[15:1] == {3'b000, $past(req.file_addr[12:1])} && resp.dest_sel == 4'h0
        && resp.ea[0] == $past(req.file_addr[0] && !req.y_space))
    else $error("file direct address wrong");
  indirect_ptr_a: assert property (s_req(MODE_INDIRECT) ##0 !y_refuse // [R11]
    |=> resp.ea == {$past(req.ptr_val[15:1]), $past(req.ptr_val[0] && !req.y_space)}
        && !resp.wb_en)
    else $error("indirect address or write-back wrong");
  post_modify_a: assert property (s_req(MODE_POST_MOD) ##0 !y_refuse // [R12]
    |=> resp.ea == {$past(req.ptr_val[15:1]), $past(req.ptr_val[0] && !req.y_space)}
        && resp.wb_en
        && (!plain_q || resp.wb_val == 16'($past(req.ptr_val) + $past(req.literal))))
    else $error("post-modify wrong");
  pre_modify_a: assert property (s_req(MODE_PRE_MOD) ##0 !y_refuse // [R13]
    |=> resp.wb_en && resp.wb_val == resp.ea
        && (!plain_q || resp.ea == 16'($past(req.ptr_val) + $past(req.literal))))
    else $error("pre-modify wrong");
  reg_offset_a: assert property (s_req(MODE_REG_OFFSET) ##0 !y_refuse // [R14]
    |=> !plain_q || resp.ea == 16'($past(req.ptr_val) + $past(req.base_val)))
    else $error("register offset sum wrong");
  lit_offset_a: assert property (s_req(MODE_LIT_OFFSET) ##0 !y_refuse // [R15]
    |=> !plain_q || resp.ea == 16'($past(req.ptr_val) + $past(req.literal)))
    else $error("literal offset sum wrong");
  offset_no_wb_a: assert property (req.valid && (req.mode == MODE_REG_OFFSET // [R19]
    || req.mode == MODE_LIT_OFFSET) |=> !resp.wb_en)
    else $error("offset mode wrote pointer back");
  y_refuse_a: assert property (req.valid && y_refuse // [R2]
    |=> resp.fault && !resp.wb_en && !resp.ea_used)
    else $error("Y request not refused");
  x_circ_gate_a: assert property (req.valid && !req.y_space // [R16]
    && (!s_q.x_en || s_q.x_sel == `AGU_SEL_NONE) |=> !resp.circ_applied)
    else $error("X circular used while off");
  y_circ_gate_a: assert property (req.valid && req.y_space // [R17]
    && (!s_q.y_en || s_q.y_sel == `AGU_SEL_NONE) |=> !resp.circ_applied)
    else $error("Y circular used while off");
  rev_gate_a: assert property (req.valid && (req.prog_space || !s_q.rev_en // [R18]
    || s_q.rev_sel == `AGU_SEL_NONE || !is_inc) |=> !resp.rev_applied)
    else $error("reversed order used while off");
  reg_direct_a: assert property (s_req(MODE_REG_DIRECT) ##0 !y_refuse // [R10]
    |=> resp.operand_is_reg && resp.operand2 == $past(req.ptr_val) && !resp.ea_used)
    else $error("register direct operand wrong");

endmodule

// ==== agu_core_model.sv ====
`timescale 1ns/1ps

// ==========================================
// Decoder and working register file stand-in
module agu_core_model (
  // Clock and reset
  input  wire logic               aclk,
  input  wire logic               aresetn,
  // Request built by the bench
  input  wire logic               issue,
  input  wire logic               load,
  input  wire agu_pkg::agu_req_t  cmd,
  // Answer from the generators
  input  wire agu_pkg::agu_resp_t resp,
  // Request to the generators
  output agu_pkg::agu_req_t       req
);
  import agu_pkg::*;

  logic [15:0] wfile [16];
  agu_req_t    built;

  always_comb begin
    built = cmd;
    built.ptr_val = wfile[cmd.ptr_sel];
    built.base_val = wfile[cmd.base_sel];
    // Idle cycles show a scrambled pattern, not the last request
    if (issue) begin
      req = built;
    end else begin
      req = agu_req_t'(~built);
    end
    req.valid = issue;
  end

  // Pointer write-back taken from the answer
  always @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 16; i++) begin
        wfile[i] <= 16'h0000;
      end
    end else if (load) begin
      wfile[cmd.ptr_sel] <= cmd.ptr_val;
      wfile[cmd.base_sel] <= cmd.base_val;
    end else if (resp.valid && resp.wb_en) begin
      wfile[resp.wb_sel] <= resp.wb_val;
    end
  end
endmodule

// ==== tb.sv ====
`timescale 1ns/1ps

module tb;
  import agu_pkg::*;

  localparam logic [11:0] A_MODE = 12'h118;
  localparam logic [11:0] A_XS   = 12'h120;
  localparam logic [11:0] A_XE   = 12'h128;
  localparam logic [11:0] A_YS   = 12'h130;
  localparam logic [11:0] A_YE   = 12'h138;
  localparam logic [11:0] A_REV  = 12'h140;
  localparam logic [11:0] A_STAT = 12'h180;
  localparam logic [11:0] A_NONE = 12'h1fc;

  logic        aclk, aresetn, issue, load;
  agu_req_t    cmd, req;
  agu_resp_t   resp;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, r;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [31:0] seed, d;
  int          fail_count, checked, cyc;

  address_generator_units dut (.aclk(aclk), .aresetn(aresetn), .req(req), .resp(resp),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  agu_core_model p (.aclk(aclk), .aresetn(aresetn), .issue(issue), .load(load), .cmd(cmd),
    .resp(resp), .req(req));

  // ==========================================
  // Helpers
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic agu_req_t mk(input agu_mode_t m, input logic [3:0] ps,
                                  input logic [15:0] lit, input logic [3:0] fl);
    agu_req_t c;
    c = '0;
    c.mode = m;
    c.ptr_sel = ps;
    c.base_sel = ps ^ 4'h1;
    c.literal = lit;
    {c.y_space, c.prog_space, c.mac_class, c.byte_op} = fl;
    return c;
  endfunction

  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    if (seen !== exp) begin
      $display("BAD %s expected %h seen %h", n, exp, seen);
      fail_count++;
    end
    checked++;
  endtask

  task automatic print_verdict();
    if (fail_count == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic wr(input logic [11:0] a, input logic [15:0] v);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {16'h0000, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic rd(input logic [11:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask

  // One request; adj is the circular or reversed correction, fl is {rev, circ}
  task automatic run(input agu_req_t c, input logic [15:0] pv, input logic [15:0] bv,
                     input logic [15:0] adj, input logic [1:0] fl);
    logic [15:0] addr, wv;
    logic        we, used, flt;
    flt = c.y_space && (c.byte_op || !c.mac_class);
    used = !flt && c.mode != MODE_REG_DIRECT;
    we = !flt && (c.mode == MODE_POST_MOD || c.mode == MODE_PRE_MOD);
    wv = pv + c.literal + adj;
    addr = pv;
    case (c.mode)
      MODE_FILE_DIRECT: addr = c.move_full ? c.move_addr : {3'h0, c.file_addr};
      MODE_PRE_MOD:     addr = wv;
      MODE_REG_OFFSET:  addr = pv + bv + adj;
      MODE_LIT_OFFSET:  addr = pv + c.literal + adj;
      default:          addr = pv;
    endcase
    if (c.y_space) begin
      addr[0] = 1'b0;
      wv[0] = 1'b0;
    end
    c.ptr_val = pv;
    c.base_val = bv;
    @(posedge aclk);
    cmd <= c;
    load <= 1'b1;
    @(posedge aclk);
    load <= 1'b0;
    issue <= 1'b1;
    @(posedge aclk);
    issue <= 1'b0;
    #1;
    chk("valid", resp.valid, 1);
    chk("fault", resp.fault, flt);
    chk("ea_used", resp.ea_used, used);
    if (used) chk("ea", resp.ea, addr);
    chk("operand1", resp.operand1, bv);
    chk("dest_sel", resp.dest_sel, (c.mode == MODE_FILE_DIRECT && !flt) ? 4'h0 : c.base_sel);
    chk("operand2", resp.operand2, (c.mode == MODE_REG_DIRECT && !flt) ? pv : c.literal);
    chk("op_is_reg", resp.operand_is_reg, c.mode == MODE_REG_DIRECT && !flt);
    chk("wb_sel", resp.wb_sel, c.ptr_sel);
    chk("wb_en", resp.wb_en, we);
    chk("circ", resp.circ_applied, fl[0]);
    chk("rev", resp.rev_applied, fl[1]);
    @(posedge aclk);
    #1;
    chk("pointer", p.wfile[c.ptr_sel], we ? wv : pv);
  endtask

  // ==========================================
  // Clock and timeout
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      print_verdict();
    end
  end

  // ==========================================
  // Main sequence
  initial begin
    agu_req_t c;
    {aresetn, issue, load, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
    cmd = '0;
    seed = 32'd48;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(A_MODE); chk("mode_rst", d, 32'h0);
    rd(A_XE); chk("xend_rst", d, 32'h1);
    rd(A_REV); chk("rev_rst", d, 32'h0);
    wr(A_XS, 16'h1235); chk("wr_ok", r, 2'h0);
    rd(A_XS); chk("xstart", d, 32'h1234);
    wr(A_NONE, 16'h5555); chk("wr_unmapped", r, 2'h2);
    rd(A_NONE); chk("rd_unmapped", {r, d[29:0]}, 32'h80000000);
    wr(A_STAT, 16'h0001); chk("wr_status", r, 2'h2);
    // Random linear traffic
    repeat (60) begin
      c = mk(agu_mode_t'(rnd() % 7), 4'(rnd()), 16'(rnd()), 4'(rnd()));
      c.file_addr = 13'(rnd());
      c.move_addr = 16'(rnd());
      c.move_full = 1'(rnd());
      run(c, 16'(rnd()), 16'(rnd()), 16'h0, 2'b00);
    end
    // Circular buffers in each space, other space untouched
    for (int s = 0; s < 2; s++) begin
      wr(s ? A_YS : A_XS, 16'h1000);
      wr(s ? A_YE : A_XE, 16'h100f);
      wr(A_MODE, s ? 16'h4f3f : 16'h8ff3);
      run(mk(MODE_POST_MOD, 3, 2, {s[0], 1'b0, s[0], 1'b0}), 16'h100e, 0, 16'hfff0, 2'b01);
      run(mk(MODE_PRE_MOD, 3, 2, {s[0], 1'b0, s[0], 1'b0}), 16'h100e, 0, 16'hfff0, 2'b01);
      run(mk(MODE_POST_MOD, 3, 2, {!s[0], 1'b0, !s[0], 1'b0}), 16'h100e, 0, 0, 2'b00);
    end
    wr(A_MODE, 16'h8ff3);
    run(mk(MODE_POST_MOD, 3, 2, 4'b0100), 16'h100e, 0, 16'hfff0, 2'b01);
    run(mk(MODE_LIT_OFFSET, 3, 4, 4'b0000), 16'h100e, 0, 16'hfff0, 2'b01);
    wr(A_MODE, 16'hcfff);
    run(mk(MODE_POST_MOD, 3, 2, 4'b0000), 16'h100e, 0, 0, 2'b00);
    // Reversed order sequencing
    wr(A_MODE, 16'h03ff);
    wr(A_REV, 16'h8008);
    run(mk(MODE_POST_MOD, 3, 2, 4'b0000), 16'h2000, 0, 16'h000e, 2'b10);
    run(mk(MODE_POST_MOD, 3, 2, 4'b0100), 16'h2000, 0, 0, 2'b00);
    run(mk(MODE_INDIRECT, 3, 2, 4'b0000), 16'h2000, 0, 0, 2'b00);
    wr(A_REV, 16'h0008);
    run(mk(MODE_POST_MOD, 3, 2, 4'b0000), 16'h2000, 0, 0, 2'b00);
    rd(A_STAT); chk("status", d, 32'h0000_2000);
    run(mk(MODE_INDIRECT, 3, 2, 4'b1000), 16'h2000, 0, 0, 2'b00);
    rd(A_STAT); chk("status_fault", d, 32'h0001_0000);
    print_verdict();
  end
endmodule
